// file: cwd_pkg.sv
package cwd_pkg;

  localparam int CFG_W  = 14;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  typedef logic [CFG_W-1:0] cwd_word_type;

  // Erased flash reads all ones
  localparam cwd_word_type CFG_BLANK       = 14'h3FFF;
  localparam cwd_word_type CFG_UNIMPL_MASK = 14'h3104;
  // Arbitrary key; guards against a stray write wiping the word
  localparam cwd_word_type ERASE_KEY       = 14'h25A5;

  localparam int CLOCK_OUTPUT_PIN_BIT  = 11;
  localparam int BOR_LSB     = 9;
  localparam int CP_BIT      = 7;
  localparam int RSTPIN_BIT  = 6;
  localparam int POWERUP_TIMER_BIT    = 5;
  localparam int WDT_LSB     = 3;
  localparam int OSC_LSB     = 0;

  localparam logic [1:0] POL_OFF   = 2'h0;
  localparam logic [1:0] POL_SW    = 2'h1;
  localparam logic [1:0] POL_SLEEP = 2'h2;
  localparam logic [1:0] POL_ON    = 2'h3;

  localparam logic [1:0] OSC_INTERNAL = 2'h0;

  localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PROG   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ERASE  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;

  localparam int CTRL_SWBOR_BIT = 0;
  localparam int CTRL_SWWDT_BIT = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic {BUS_IDLE, BUS_ANSWER} cwd_bus_state_type;

  typedef struct packed {
    logic       clock_output_pin_en;
    logic [1:0] bor_policy;
    logic       ext_reset_en;
    logic       pullup_forced;
    logic       powerup_timer_en;
    logic [1:0] wdt_policy;
    logic [1:0] osc_select;
  } cwd_settings_type;

endpackage : cwd_pkg

// file: cwd_policy_decode.sv
`timescale 1ns/10ps
module cwd_policy_decode (
  input  wire logic [1:0] policy_i,
  input  wire logic       sw_enable_i,
  input  wire logic       sleep_i,
  output logic            active_o
);

  always_comb begin
    case (policy_i)
      cwd_pkg::POL_SW:    active_o = sw_enable_i;
      cwd_pkg::POL_SLEEP: active_o = ~sleep_i;
      cwd_pkg::POL_ON:    active_o = 1'h1;
      default:            active_o = 1'h0;
    endcase
  end

endmodule : cwd_policy_decode

// file: cwd_nv_word.sv
`timescale 1ns/10ps
module cwd_nv_word (
  input  wire logic                  core_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  program_i,
  input  wire cwd_pkg::cwd_word_type program_data_i,
  input  wire logic                  erase_i,
  output cwd_pkg::cwd_word_type      word_o
);

  cwd_pkg::cwd_word_type stored_r;

  // Programming only clears bits, so a set protect bit can't return to 1
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      stored_r <= cwd_pkg::CFG_BLANK;
    end else if (erase_i) begin
      stored_r <= cwd_pkg::CFG_BLANK;
    end else if (program_i) begin
      stored_r <= stored_r & program_data_i;
    end
  end

  assign word_o = stored_r | cwd_pkg::CFG_UNIMPL_MASK;

endmodule : cwd_nv_word

// file: cwd_top.sv
// Contract
// - Bit 11 low drives clock output, high frees it
// - Brown-out policy 01 follows software enable bit
// - Policy 10: brown-out active running, off sleeping
// - Policy 11 always on, 00 always off
// - Protect bit low blocks external program access
// - Protection removed only by bulk erase or system reset
// - Low-voltage programming forces reset pin, pull-up
// - Otherwise bit 6 selects reset or input
// - Power-up timer bit active low
// - Brown-out and power-up timer decoded independently
// - Watchdog policy 01 follows software enable bit
// - Policy 10: watchdog runs awake, stops sleeping
// - Policy 11 watchdog always runs
// - Policy 00 watchdog always off
// - Oscillator 11/10/01 select external clock modes
// - Oscillator 00 internal, clock pin freed
// - Unimplemented word bits read as one
// - Blank or erased word reads all ones
`timescale 1ns/10ps
module cwd_top (
  input  wire logic                         core_clk_i,
  input  wire logic                         sys_rst_i,
  input  wire logic [cwd_pkg::ADDR_W-1:0]   avs_address_i,
  input  wire logic                         avs_read_i,
  input  wire logic                         avs_write_i,
  input  wire logic [cwd_pkg::DATA_W-1:0]   avs_writedata_i,
  input  wire logic [3:0]                   avs_byteenable_i,
  output logic      [cwd_pkg::DATA_W-1:0]   avs_readdata_o,
  output logic                              avs_waitrequest_o,
  output logic      [1:0]                   avs_response_o,
  input  wire logic                         sleep_i,
  input  wire logic                         core_reset_req_i,
  input  wire logic                         external_reset_input_n_i,
  input  wire logic                         low_voltage_prog_enable_i,
  input  wire logic                         pin_pullup_control_i,
  output logic                              core_reset_o,
  output logic                              clock_output_pin_o,
  output logic                              clock_output_pin_oe_n_o,
  output logic                              brownout_reset_active_o,
  output logic                              watchdog_run_o,
  output logic                              powerup_timer_en_o,
  output logic                              prog_mem_ext_access_o,
  output logic                              ext_reset_enable_o,
  output logic                              reset_pin_pullup_o,
  output logic      [1:0]                   oscillator_select_o,
  output logic                              internal_oscillator_o,
  output logic                              clock_input_pin_release_o
);

  cwd_pkg::cwd_bus_state_type bus_state_r;
  cwd_pkg::cwd_settings_type  settings_r;
  cwd_pkg::cwd_settings_type  settings_nxt;
  cwd_pkg::cwd_word_type      word;
  cwd_pkg::cwd_word_type      prog_data;

  logic                       sw_brownout_enable_r;
  logic                       sw_watchdog_enable_r;
  logic                       reset_req;
  logic                       bor_active;
  logic                       wdt_active;
  logic                       code_protect_n;
  logic                       do_write;
  logic                       prog_pulse;
  logic                       erase_pulse;
  logic                       addr_hit;
  logic [cwd_pkg::DATA_W-1:0] read_mux;
  logic                       bus_take;
  localparam int              STAT_BASE = $bits(cwd_pkg::cwd_settings_type);

  // Bus slave: one wait state, write commits on the accepting edge

  assign do_write = (bus_state_r == cwd_pkg::BUS_ANSWER) && avs_write_i;
  assign bus_take = (bus_state_r == cwd_pkg::BUS_IDLE) && (avs_read_i || avs_write_i);

  always_comb begin
    addr_hit = 1'h1;
    case (avs_address_i)
      cwd_pkg::REG_CONFIG,
      cwd_pkg::REG_PROG,
      cwd_pkg::REG_ERASE,
      cwd_pkg::REG_CTRL,
      cwd_pkg::REG_STATUS: addr_hit = 1'h1;
      default:             addr_hit = 1'h0;
    endcase
  end

  always_comb begin
    read_mux = '0;
    case (avs_address_i)
      cwd_pkg::REG_CONFIG: read_mux = {{(cwd_pkg::DATA_W-cwd_pkg::CFG_W){1'h0}}, word};
      cwd_pkg::REG_CTRL: begin
        read_mux[cwd_pkg::CTRL_SWBOR_BIT] = sw_brownout_enable_r;
        read_mux[cwd_pkg::CTRL_SWWDT_BIT] = sw_watchdog_enable_r;
      end
      cwd_pkg::REG_STATUS: begin
        read_mux[STAT_BASE-1:0] = settings_r;
        read_mux[STAT_BASE]     = wdt_active;
        read_mux[STAT_BASE+1]   = bor_active;
        read_mux[STAT_BASE+2]   = code_protect_n;
      end
      default: read_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      bus_state_r <= cwd_pkg::BUS_IDLE;
    end else begin
      case (bus_state_r)
        cwd_pkg::BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_state_r <= cwd_pkg::BUS_ANSWER;
          end
        end
        cwd_pkg::BUS_ANSWER: begin
          bus_state_r <= cwd_pkg::BUS_IDLE;
        end
        default: begin
          bus_state_r <= cwd_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Low for the answer cycle only, so a held request is never taken twice
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'h1;
    end else begin
      avs_waitrequest_o <= ~bus_take;
    end
  end

  // Zero outside the answer cycle so stale data never looks valid
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= '0;
    end else if (bus_take && avs_read_i) begin
      avs_readdata_o <= read_mux;
    end else begin
      avs_readdata_o <= '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      avs_response_o <= cwd_pkg::RESP_OKAY;
    end else if (bus_take && !addr_hit) begin
      avs_response_o <= cwd_pkg::RESP_DECERR;
    end else begin
      avs_response_o <= cwd_pkg::RESP_OKAY;
    end
  end

  // Configuration word storage, written by the external programmer

  // Programming needs both low byte lanes so a half word can't slip in
  assign prog_pulse  = do_write && (avs_address_i == cwd_pkg::REG_PROG)
                       && (avs_byteenable_i[1:0] == 2'h3);
  assign prog_data   = avs_writedata_i[cwd_pkg::CFG_W-1:0];
  // Bulk erase and system reset are the only ways back to an unprotected word
  assign erase_pulse = do_write && (avs_address_i == cwd_pkg::REG_ERASE)
                       && (avs_byteenable_i[1:0] == 2'h3)
                       && (prog_data == cwd_pkg::ERASE_KEY);

  cwd_nv_word u_nv_word (
    .core_clk_i     (core_clk_i),
    .sys_rst_i      (sys_rst_i),
    .program_i      (prog_pulse),
    .program_data_i (prog_data),
    .erase_i        (erase_pulse),
    .word_o         (word)
  );

  // Protection acts on the live word so a freshly set bit locks at once
  assign code_protect_n = word[cwd_pkg::CP_BIT];

  // Runtime software enables

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sw_brownout_enable_r <= 1'h0;
    end else if (do_write && (avs_address_i == cwd_pkg::REG_CTRL) && avs_byteenable_i[0]) begin
      sw_brownout_enable_r <= avs_writedata_i[cwd_pkg::CTRL_SWBOR_BIT];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sw_watchdog_enable_r <= 1'h0;
    end else if (do_write && (avs_address_i == cwd_pkg::REG_CTRL) && avs_byteenable_i[0]) begin
      sw_watchdog_enable_r <= avs_writedata_i[cwd_pkg::CTRL_SWWDT_BIT];
    end
  end

  // Decode and latch during reset

  always_comb begin
    settings_nxt.clock_output_pin_en  = ~word[cwd_pkg::CLOCK_OUTPUT_PIN_BIT];
    settings_nxt.bor_policy = word[cwd_pkg::BOR_LSB +: 2];
    settings_nxt.powerup_timer_en    = ~word[cwd_pkg::POWERUP_TIMER_BIT];
    settings_nxt.wdt_policy = word[cwd_pkg::WDT_LSB +: 2];
    settings_nxt.osc_select = word[cwd_pkg::OSC_LSB +: 2];
    if (low_voltage_prog_enable_i) begin
      settings_nxt.ext_reset_en  = 1'h1;
      settings_nxt.pullup_forced = 1'h1;
    end else begin
      settings_nxt.ext_reset_en  = word[cwd_pkg::RSTPIN_BIT];
      settings_nxt.pullup_forced = word[cwd_pkg::RSTPIN_BIT];
    end
  end

  // Pin reset is only honoured once the latched decode allows it
  assign reset_req = core_reset_req_i
                     | (settings_r.ext_reset_en & ~external_reset_input_n_i);

  // Reloading only in reset keeps the core clocks and resets steady
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || reset_req) begin
      settings_r <= settings_nxt;
    end
  end

  // Run-time policies

  cwd_policy_decode u_bor_policy (
    .policy_i    (settings_r.bor_policy),
    .sw_enable_i (sw_brownout_enable_r),
    .sleep_i     (sleep_i),
    .active_o    (bor_active)
  );

  cwd_policy_decode u_wdt_policy (
    .policy_i    (settings_r.wdt_policy),
    .sw_enable_i (sw_watchdog_enable_r),
    .sleep_i     (sleep_i),
    .active_o    (wdt_active)
  );

  // Registered outputs

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      core_reset_o <= 1'h1;
    end else begin
      core_reset_o <= reset_req;
    end
  end

  // Clock output toggles each cycle while enabled; pin freed otherwise
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      clock_output_pin_o <= 1'h0;
    end else begin
      clock_output_pin_o <= settings_r.clock_output_pin_en & ~clock_output_pin_o;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      clock_output_pin_oe_n_o <= 1'h1;
    end else begin
      clock_output_pin_oe_n_o <= ~settings_r.clock_output_pin_en;
    end
  end

  // Sleep and the software bits act at once; only the policy is latched
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      brownout_reset_active_o <= 1'h0;
    end else begin
      brownout_reset_active_o <= bor_active;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      watchdog_run_o <= 1'h0;
    end else begin
      watchdog_run_o <= wdt_active;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      powerup_timer_en_o <= 1'h0;
    end else begin
      powerup_timer_en_o <= settings_r.powerup_timer_en;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      prog_mem_ext_access_o <= 1'h0;
    end else begin
      prog_mem_ext_access_o <= code_protect_n;
    end
  end

  // With the reset function off, the pin's own pull-up control rules
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ext_reset_enable_o <= 1'h1;
    end else begin
      ext_reset_enable_o <= settings_r.ext_reset_en;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reset_pin_pullup_o <= 1'h1;
    end else begin
      reset_pin_pullup_o <= settings_r.pullup_forced | pin_pullup_control_i;
    end
  end

  // Source select and pin release follow one latched field, never the live word
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      oscillator_select_o <= cwd_pkg::OSC_INTERNAL;
    end else begin
      oscillator_select_o <= settings_r.osc_select;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      internal_oscillator_o <= 1'h1;
    end else begin
      internal_oscillator_o <= (settings_r.osc_select == cwd_pkg::OSC_INTERNAL);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      clock_input_pin_release_o <= 1'h1;
    end else begin
      clock_input_pin_release_o <= (settings_r.osc_select == cwd_pkg::OSC_INTERNAL);
    end
  end

endmodule : cwd_top

// file: cwd_chk.sv
`timescale 1ns/10ps
module cwd_chk (
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  input wire logic [31:0] avs_readdata_o,
  input wire logic [1:0]  avs_response_o,
  input wire logic        core_reset_req_i,
  input wire logic        external_reset_input_n_i,
  input wire logic        core_reset_o,
  input wire logic        clock_output_pin_o,
  input wire logic        clock_output_pin_oe_n_o,
  input wire logic        powerup_timer_en_o,
  input wire logic        ext_reset_enable_o,
  input wire logic        reset_pin_pullup_o,
  input wire logic [1:0]  oscillator_select_o,
  input wire logic        internal_oscillator_o,
  input wire logic        clock_input_pin_release_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_taken;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  a_bus_one_wait: assert property (s_taken |=> s_answer)
    else $error("Request not answered after one wait state");
  a_unimpl_ones: assert property (
    s_taken ##0 (avs_read_i && avs_address_i == cwd_pkg::REG_CONFIG)
    |=> (avs_readdata_o[13:0] & cwd_pkg::CFG_UNIMPL_MASK) == cwd_pkg::CFG_UNIMPL_MASK)
    else $error("Unimplemented word bits read as zero");
  a_unmapped_err: assert property (
    s_taken ##0 !(avs_address_i inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})
    |=> avs_response_o == cwd_pkg::RESP_DECERR && avs_readdata_o == 32'h0000_0000)
    else $error("Unmapped access not answered with decode error");
  a_clock_output_pin_idle: assert property (clock_output_pin_oe_n_o |-> !clock_output_pin_o)
    else $error("Clock output active while not driven");
  a_clock_output_pin_toggle: assert property (
    !clock_output_pin_oe_n_o [*2] |-> $changed(clock_output_pin_o))
    else $error("Clock output not toggling while enabled");
  a_osc_internal: assert property (
    internal_oscillator_o == (oscillator_select_o == cwd_pkg::OSC_INTERNAL)
    && clock_input_pin_release_o == internal_oscillator_o)
    else $error("Internal oscillator and pin release disagree with select");
  a_reset_pullup: assert property (ext_reset_enable_o |-> reset_pin_pullup_o)
    else $error("Reset pin function without pull-up");
  a_settings_hold: assert property (
    $changed({oscillator_select_o, powerup_timer_en_o, ext_reset_enable_o})
    |-> $past(core_reset_o))
    else $error("Latched setting changed outside a reset");
  a_reset_follow: assert property (
    external_reset_input_n_i |=> core_reset_o == $past(core_reset_req_i))
    else $error("Core reset does not follow its request");
endmodule : cwd_chk

bind cwd_top cwd_chk u_chk (.core_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_waitrequest_o, .avs_readdata_o, .avs_response_o, .core_reset_req_i,
  .external_reset_input_n_i, .core_reset_o, .clock_output_pin_o, .clock_output_pin_oe_n_o,
  .powerup_timer_en_o, .ext_reset_enable_o, .reset_pin_pullup_o, .oscillator_select_o,
  .internal_oscillator_o, .clock_input_pin_release_o);

// file: cwd_programmer.sv
`timescale 1ns/10ps
module cwd_programmer (
  input  wire logic        core_clk_i,
  input  wire logic        avs_waitrequest_i,
  input  wire logic [31:0] avs_readdata_i,
  input  wire logic [1:0]  avs_response_i,
  output logic      [7:0]  avs_address_o,
  output logic             avs_read_o,
  output logic             avs_write_o,
  output logic      [31:0] avs_writedata_o
);
  initial begin
    avs_address_o = 8'h00;
    avs_read_o = 1'h0;
    avs_write_o = 1'h0;
    avs_writedata_o = 32'h0000_0000;
  end

  // Bounded wait so a dead slave cannot hang the run
  task automatic xfer(input logic wr_en, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic [1:0] resp, output logic ok);
    int n;
    @(posedge core_clk_i);
    avs_address_o   <= addr;
    avs_write_o     <= wr_en;
    avs_read_o      <= !wr_en;
    avs_writedata_o <= wdata;
    ok = 1'h0;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge core_clk_i);
      ok = (avs_waitrequest_i === 1'h0);
    end
    rdata = avs_readdata_i;
    resp  = avs_response_i;
    avs_read_o  <= 1'h0;
    avs_write_o <= 1'h0;
    // Released data must not keep looking valid
    avs_writedata_o <= ~wdata;
  endtask : xfer

  // Protection is only lifted by wiping the whole word
  task automatic bulk_erase(output logic ok);
    logic [31:0] rdata;
    logic [1:0]  resp;
    xfer(1'h1, cwd_pkg::REG_ERASE, {18'h0_0000, cwd_pkg::ERASE_KEY}, rdata, resp, ok);
  endtask : bulk_erase
endmodule : cwd_programmer

// file: cwd_top_bench.sv
`timescale 1ns/10ps
`define CHECK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module cwd_top_bench;
  logic        core_clk_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [7:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0]  avs_byteenable_i;
  logic [1:0]  avs_response_o, oscillator_select_o, last_osc;
  logic        sleep_i, core_reset_req_i, external_reset_input_n_i, low_voltage_prog_enable_i;
  logic        pin_pullup_control_i, core_reset_o, clock_output_pin_o, clock_output_pin_oe_n_o;
  logic        brownout_reset_active_o, watchdog_run_o, powerup_timer_en_o;
  logic        prog_mem_ext_access_o, ext_reset_enable_o, reset_pin_pullup_o;
  logic        internal_oscillator_o, clock_input_pin_release_o;
  int          errors, check_count, i;
  cwd_pkg::cwd_word_type words [4] = '{14'h3FFF, 14'h3514, 14'h3BAD, 14'h3146};

  cwd_top DUT (.core_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o,
    .sleep_i, .core_reset_req_i, .external_reset_input_n_i, .low_voltage_prog_enable_i,
    .pin_pullup_control_i, .core_reset_o, .clock_output_pin_o, .clock_output_pin_oe_n_o,
    .brownout_reset_active_o, .watchdog_run_o, .powerup_timer_en_o, .prog_mem_ext_access_o,
    .ext_reset_enable_o, .reset_pin_pullup_o, .oscillator_select_o, .internal_oscillator_o,
    .clock_input_pin_release_o);

  cwd_programmer prog (.core_clk_i, .avs_waitrequest_i(avs_waitrequest_o),
    .avs_readdata_i(avs_readdata_o), .avs_response_i(avs_response_o),
    .avs_address_o(avs_address_i), .avs_read_o(avs_read_i), .avs_write_o(avs_write_i),
    .avs_writedata_o(avs_writedata_i));

  function automatic logic pol(input logic [1:0] p, input logic sw, input logic slp);
    return p == 2'h3 || (p == 2'h2 && !slp) || (p == 2'h1 && sw);
  endfunction : pol

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic [1:0] rs);
    logic ok;
    prog.xfer(wr_en, a, d, rd, rs, ok);
    if (ok !== 1'h1) begin
      errors++;
      summarize();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic [1:0]  rs;
    bus(1'h1, a, d, rd, rs);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] rd;
    logic [1:0]  rs;
    bus(1'h0, a, 32'h0000_0000, rd, rs);
    `CHECK(rd, e)
    `CHECK(rs, er)
  endtask : rd_chk

  task automatic erase();
    logic ok;
    prog.bulk_erase(ok);
    if (ok !== 1'h1) begin
      errors++;
      summarize();
    end
  endtask : erase

  // Unimplemented bits are programmed as zero so their read-back proves the forcing
  task automatic apply(input cwd_pkg::cwd_word_type w, input logic low_voltage_prog_enable);
    int k;
    erase();
    wr(cwd_pkg::REG_PROG, {18'h0_0000, w & ~cwd_pkg::CFG_UNIMPL_MASK});
    rd_chk(cwd_pkg::REG_CONFIG, {18'h0_0000, w}, cwd_pkg::RESP_OKAY);
    `CHECK(oscillator_select_o, last_osc)
    low_voltage_prog_enable_i <= low_voltage_prog_enable;
    core_reset_req_i <= 1'h1;
    @(posedge core_clk_i);
    core_reset_req_i <= 1'h0;
    repeat (3) @(posedge core_clk_i);
    `CHECK(clock_output_pin_oe_n_o, w[11])
    `CHECK(powerup_timer_en_o, !w[5])
    `CHECK(ext_reset_enable_o, low_voltage_prog_enable | w[6])
    `CHECK(oscillator_select_o, w[1:0])
    `CHECK(clock_input_pin_release_o, w[1:0] == 2'h0)
    `CHECK(prog_mem_ext_access_o, w[7])
    external_reset_input_n_i <= 1'h0;
    repeat (2) @(posedge core_clk_i);
    `CHECK(core_reset_o, low_voltage_prog_enable | w[6])
    external_reset_input_n_i <= 1'h1;
    for (k = 0; k < 8; k++) begin
      wr(cwd_pkg::REG_CTRL, {30'h0000_0000, k[1:0]});
      rd_chk(cwd_pkg::REG_CTRL, {30'h0000_0000, k[1:0]}, cwd_pkg::RESP_OKAY);
      sleep_i <= k[2];
      pin_pullup_control_i <= k[0];
      repeat (3) @(posedge core_clk_i);
      `CHECK(brownout_reset_active_o, pol(w[10:9], k[0], k[2]))
      `CHECK(watchdog_run_o, pol(w[4:3], k[1], k[2]))
      `CHECK(reset_pin_pullup_o, low_voltage_prog_enable | w[6] | k[0])
    end
    last_osc = w[1:0];
  endtask : apply

  initial begin
    core_clk_i = 1'h0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  initial begin
    errors = 0;
    check_count = 0;
    last_osc = 2'h3;
    sys_rst_i = 1'h1;
    sleep_i = 1'h0;
    core_reset_req_i = 1'h0;
    external_reset_input_n_i = 1'h1;
    low_voltage_prog_enable_i = 1'h0;
    pin_pullup_control_i = 1'h0;
    avs_byteenable_i = 4'hF;
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'h0;
    repeat (2) @(posedge core_clk_i);
    rd_chk(cwd_pkg::REG_CONFIG, {18'h0_0000, cwd_pkg::CFG_BLANK}, cwd_pkg::RESP_OKAY);
    `CHECK(oscillator_select_o, 2'h3)
    rd_chk(cwd_pkg::REG_STATUS, 32'h0000_1DEF, cwd_pkg::RESP_OKAY);
    wr(8'h20, 32'h0000_FFFF);
    rd_chk(8'h20, 32'h0000_0000, cwd_pkg::RESP_DECERR);
    for (i = 0; i < 4; i++) apply(words[i], i == 1);
    // Last word leaves the part protected; only the keyed erase or a system reset may undo it
    wr(cwd_pkg::REG_PROG, 32'h0000_3FFF);
    wr(cwd_pkg::REG_ERASE, 32'h0000_1234);
    wr(cwd_pkg::REG_CONFIG, 32'h0000_0000);
    rd_chk(cwd_pkg::REG_CONFIG, 32'h0000_3146, cwd_pkg::RESP_OKAY);
    `CHECK(prog_mem_ext_access_o, 1'h0)
    erase();
    repeat (2) @(posedge core_clk_i);
    `CHECK(prog_mem_ext_access_o, 1'h1)
    rd_chk(cwd_pkg::REG_CONFIG, {18'h0_0000, cwd_pkg::CFG_BLANK}, cwd_pkg::RESP_OKAY);
    summarize();
  end
endmodule : cwd_top_bench
